// file: verilog/rpm_pkg.sv
// constants and types shared by both ends of the power-mode link
package rpm_pkg;
  // base rate: 1 ms tick derived from the 100 MHz clock
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TICK_MS         = 1;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000 * TICK_MS;
  // timing figures in ms
  localparam int unsigned PULSE_MS        = 200;   // toggle pulse width
  localparam int unsigned PULSE_MIN_MS    = 100;   // shortest accepted pulse
  localparam int unsigned BOOT_WAIT_MS    = 1000;  // wait after power-up
  localparam int unsigned SHUTDOWN_MS     = 1000;  // longest shutdown
  localparam int unsigned HIB_DELAY_MS    = 50;    // short delay into hibernate
  localparam int unsigned STOP_MS         = 500;   // device shutdown work time
  localparam int unsigned MSG_WAIT_MS     = 1000;  // wait for first message
  localparam int unsigned PTF_PERIOD_MS   = 7_200_000; // 2 hours push-to-fix sleep
  localparam int unsigned PTF_FIX_MS      = 1000;  // refresh time per wake_indicator_out
  // device power modes
  typedef enum logic [2:0] {
    RPM_OFF, RPM_FULL, RPM_STOPPING, RPM_HIB_DLY, RPM_HIB, RPM_AWARE, RPM_PTF_SLEEP, RPM_PTF_FIX
  } rpm_mode_t;
endpackage

// file: verilog/rpm_link_if.sv
// link between host sequencer and receiver power sequencer
`timescale 1ns/1ps
interface rpm_link_if;
  logic toggle;       // power toggle, driven by host
  logic supply_on;    // main supply applied, driven by host
  logic wake_ind;     // wake indicator, driven by device
  logic ant_stat;     // antenna status from external sensor
  modport dev  (input toggle, input supply_on, input ant_stat, output wake_ind);
  modport host (output toggle, output supply_on, input wake_ind);
endinterface

// file: verilog/rpm_device.sv
// receiver end: decodes toggle pulses and sequences power modes
`timescale 1ns/1ps
// What this block does
// - host starts firmware with 200 ms pulse
// - first pulse after wake rise or 1 s
// - host re-pulses in uart mode when no messages appear
// - pulse or message in full power stops
// - shutdown ends within 1 s, supply held
// - shutdown flushes critical data; no abrupt drop
// - pulse requests fix, leaves aware mode
// - push-to-fix sleeps 2 h, refreshes periodically
// - host pulse forces push-to-fix fix
// - command or pulse enters hibernate after delay
// - hibernate keeps clock and retained memory
// - pulse wakes module from hibernate
// - module switches antenna supply when needed
// - sensor status high only in 9-16 mA
module rpm_device
  import rpm_pkg::*;
#(
  parameter int unsigned PTF_PERIOD_CYC = PTF_PERIOD_MS,  // ms ticks between wakeups
  parameter int unsigned MS_CYC         = CYC_PER_MS      // clocks per ms tick
) (
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  rpm_link_if.dev   link,
  input  wire logic shutdown_cmd_i,   // shutdown message, one-cycle pulse
  input  wire logic ptf_cmd_i,        // enter push-to-fix, one-cycle pulse
  input  wire logic aware_cmd_i,      // enter aware mode, one-cycle pulse
  input  wire logic hib_sel_i,        // 1: shutdown goes to hibernate
  input  wire logic flush_done_i,     // critical data writes complete
  output logic      flush_req_o,      // request write of critical data
  output logic      ant_pwr_o,        // active antenna supply switch
  output logic      ant_ok_o,         // antenna current in normal band
  output logic      rtc_run_o,        // real-time clock running
  output logic      sram_ret_o,       // retention of memory
  output logic      refresh_o,        // push-to-fix refresh pulse
  output logic [2:0] mode_o           // current mode
);
  // elaboration check: divider and sleep timer need at least two counts
  if (MS_CYC < 2 || PTF_PERIOD_CYC < 2) begin : g_bad_cfg
    $error("rpm_device: counts too small");
  end

  localparam int unsigned MIN_PULSE_TK = PULSE_MIN_MS / TICK_MS; // least pulse ticks
  localparam int unsigned STOP_TK      = STOP_MS / TICK_MS;      // max stop work
  localparam int unsigned HIB_TK       = HIB_DELAY_MS / TICK_MS; // hibernate delay
  localparam int unsigned FIX_TK       = PTF_FIX_MS / TICK_MS;   // fix duration

  // pin synchronisers (toggle, supply and sensor come from outside)
  logic [1:0] tg_s_r, sp_s_r, an_s_r;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      tg_s_r <= 2'h0;
      sp_s_r <= 2'h0;
      an_s_r <= 2'h0;
    end else begin
      tg_s_r <= {tg_s_r[0], link.toggle};
      sp_s_r <= {sp_s_r[0], link.supply_on};
      an_s_r <= {an_s_r[0], link.ant_stat};
    end
  end
  wire logic tg_w = tg_s_r[1];  // synced toggle level
  wire logic sp_w = sp_s_r[1];  // synced supply level

  // ms tick divider
  logic [31:0] div_r, div_nxt;
  logic        tick_r, tick_nxt;
  always_comb begin
    div_nxt  = div_r + 32'h1;
    tick_nxt = 1'b0;
    if (div_r >= MS_CYC - 1) begin
      div_nxt  = 32'h0;
      tick_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      div_r  <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  // pulse decoder: a high level held long enough counts on its falling edge
  logic [15:0] hi_r, hi_nxt;
  logic        tg_d_r, tg_d_nxt;
  logic        pulse_r, pulse_nxt;  // one-cycle valid toggle pulse
  always_comb begin
    tg_d_nxt  = tg_w;
    pulse_nxt = 1'b0;
    hi_nxt    = hi_r;
    if (tg_w) begin
      if (tick_r && hi_r != 16'hFFFF) hi_nxt = hi_r + 16'h1;
    end else begin
      hi_nxt = 16'h0;
      // short glitches are ignored so noise cannot power-cycle the receiver
      if (tg_d_r && hi_r >= 16'(MIN_PULSE_TK)) pulse_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      hi_r    <= 16'h0;
      tg_d_r  <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      hi_r    <= hi_nxt;
      tg_d_r  <= tg_d_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  // mode sequencer
  rpm_mode_t   st_r, st_nxt;
  logic [31:0] tm_r, tm_nxt;    // ms timer within a state
  logic        wake_r, wake_nxt;
  logic        flush_r, flush_nxt;
  logic        ref_r, ref_nxt;
  logic        ant_r, ant_nxt;
  always_comb begin
    st_nxt    = st_r;
    tm_nxt    = tick_r ? tm_r + 32'h1 : tm_r;
    flush_nxt = 1'b0;
    ref_nxt   = 1'b0;
    case (st_r)
      RPM_OFF: begin
        // firmware idles until the start pulse arrives
        if (pulse_r) begin
          st_nxt = RPM_FULL;
          tm_nxt = 32'h0;
        end
      end
      RPM_FULL: begin
        if (pulse_r || shutdown_cmd_i) begin
          st_nxt = hib_sel_i ? RPM_HIB_DLY : RPM_STOPPING;
          tm_nxt = 32'h0;
        end else if (aware_cmd_i) begin
          st_nxt = RPM_AWARE;
        end else if (ptf_cmd_i) begin
          st_nxt = RPM_PTF_SLEEP;
          tm_nxt = 32'h0;
        end
      end
      RPM_STOPPING: begin
        flush_nxt = 1'b1;
        // flush limited so shutdown never exceeds the supply hold window
        if (flush_done_i || tm_r >= 32'(STOP_TK)) begin
          st_nxt = RPM_OFF;
          tm_nxt = 32'h0;
        end
      end
      RPM_HIB_DLY: begin
        flush_nxt = 1'b1;
        if (tm_r >= 32'(HIB_TK)) st_nxt = RPM_HIB;
      end
      RPM_HIB: begin
        if (pulse_r) begin
          st_nxt = RPM_FULL;
          tm_nxt = 32'h0;
        end
      end
      RPM_AWARE: begin
        if (pulse_r) st_nxt = RPM_FULL;
      end
      RPM_PTF_SLEEP: begin
        if (pulse_r || tm_r >= PTF_PERIOD_CYC) begin
          st_nxt  = RPM_PTF_FIX;
          tm_nxt  = 32'h0;
          ref_nxt = 1'b1;
        end
      end
      RPM_PTF_FIX: begin
        if (tm_r >= 32'(FIX_TK)) begin
          st_nxt = RPM_PTF_SLEEP;
          tm_nxt = 32'h0;
        end
      end
      default: st_nxt = RPM_OFF;
    endcase
    wake_nxt = (st_nxt == RPM_FULL) || (st_nxt == RPM_PTF_FIX);
    ant_nxt  = wake_nxt;
  end
  always_ff @(posedge clk_sys_i) begin
    // loss of supply drops straight to off regardless of state
    if (!nrst_i || !sp_w) begin
      st_r    <= RPM_OFF;
      tm_r    <= 32'h0;
      wake_r  <= 1'b0;
      flush_r <= 1'b0;
      ref_r   <= 1'b0;
      ant_r   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      tm_r    <= tm_nxt;
      wake_r  <= wake_nxt;
      flush_r <= flush_nxt;
      ref_r   <= ref_nxt;
      ant_r   <= ant_nxt;
    end
  end

  // registered status outputs
  logic       rtc_r, ret_r, aok_r;
  logic [2:0] md_r;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rtc_r <= 1'b0;
      ret_r <= 1'b0;
      aok_r <= 1'b0;
      md_r  <= 3'h0;
    end else begin
      rtc_r <= sp_w;
      ret_r <= sp_w && st_r == RPM_HIB;
      aok_r <= an_s_r[1] && ant_r;
      md_r  <= st_r;
    end
  end

  assign link.wake_ind = wake_r;
  assign flush_req_o   = flush_r;
  assign ant_pwr_o     = ant_r;
  assign ant_ok_o      = aok_r;
  assign rtc_run_o     = rtc_r;
  assign sram_ret_o    = ret_r;
  assign refresh_o     = ref_r;
  assign mode_o        = md_r;
endmodule

// file: verilog/rpm_host.sv
// host end: drives supply and 200 ms toggle pulses for the receiver
`timescale 1ns/1ps
module rpm_host
  import rpm_pkg::*;
#(
  parameter int unsigned MS_CYC = CYC_PER_MS  // clocks per ms tick
) (
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  rpm_link_if.host  link,
  input  wire logic pwr_up_i,     // request supply on and start, pulse
  input  wire logic pulse_req_i,  // request one toggle pulse, pulse
  input  wire logic pwr_down_i,   // request shutdown then supply off, pulse
  input  wire logic msg_seen_i,   // receiver messages observed, level
  input  wire logic uart_mode_i,  // receiver configured for uart
  output logic      busy_o        // sequence in progress
);
  // elaboration check: the ms divider needs at least two counts
  if (MS_CYC < 2) begin : g_bad_cfg
    $error("rpm_host: MS_CYC too small");
  end
  typedef enum logic [2:0] {H_OFF, H_BOOT, H_PULSE, H_MSGW, H_IDLE, H_HOLD} rpm_hst_t;

  // wake indicator synchroniser
  logic [1:0] wk_s_r;
  logic       wk_d_r;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      wk_s_r <= 2'h0;
      wk_d_r <= 1'b0;
    end else begin
      wk_s_r <= {wk_s_r[0], link.wake_ind};
      wk_d_r <= wk_s_r[1];
    end
  end
  wire logic wk_rise = wk_s_r[1] && !wk_d_r;

  // ms tick
  logic [31:0] div_r, div_nxt;
  logic        tick_r, tick_nxt;
  // next divider count; wraps and emits one tick per ms
  always_comb begin
    div_nxt  = div_r + 32'h1;
    tick_nxt = 1'b0;
    if (div_r >= MS_CYC - 1) begin
      div_nxt  = 32'h0;
      tick_nxt = 1'b1;
    end
  end
  // divider registers, constant reset values only
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      div_r  <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  rpm_hst_t    st_r, st_nxt, ret_r, ret_nxt; // ret: state after pulse
  logic [31:0] tm_r, tm_nxt;
  logic        tg_r, tg_nxt, sup_r, sup_nxt, down_r, down_nxt;
  always_comb begin
    st_nxt   = st_r;
    ret_nxt  = ret_r;
    tm_nxt   = tick_r ? tm_r + 32'h1 : tm_r;
    tg_nxt   = 1'b0;
    sup_nxt  = sup_r;
    down_nxt = down_r;
    case (st_r)
      H_OFF: if (pwr_up_i) begin
        st_nxt  = H_BOOT;
        sup_nxt = 1'b1;
        tm_nxt  = 32'h0;
      end
      H_BOOT: if (wk_rise || tm_r >= 32'(BOOT_WAIT_MS)) begin
        st_nxt  = H_PULSE;
        ret_nxt = H_MSGW;
        tm_nxt  = 32'h0;
      end
      H_PULSE: begin
        tg_nxt = 1'b1;
        if (tm_r >= 32'(PULSE_MS)) begin
          tg_nxt = 1'b0;
          st_nxt = ret_r;
          tm_nxt = 32'h0;
        end
      end
      H_MSGW: begin
        if (!uart_mode_i || msg_seen_i) st_nxt = H_IDLE;
        else if (tm_r >= 32'(MSG_WAIT_MS)) begin
          st_nxt  = H_PULSE;
          ret_nxt = H_MSGW;
          tm_nxt  = 32'h0;
        end
      end
      H_IDLE: begin
        // pulse and power-down requests only accepted here, so pulses never overlap
        if (pwr_down_i) begin
          st_nxt   = H_PULSE;
          ret_nxt  = H_HOLD;
          down_nxt = 1'b1;
          tm_nxt   = 32'h0;
        end else if (pulse_req_i) begin
          st_nxt  = H_PULSE;
          ret_nxt = H_IDLE;
          tm_nxt  = 32'h0;
        end
      end
      H_HOLD: if (tm_r >= 32'(SHUTDOWN_MS)) begin
        st_nxt   = H_OFF;
        sup_nxt  = 1'b0;
        down_nxt = 1'b0;
      end
      default: st_nxt = H_OFF;
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      st_r   <= H_OFF;
      ret_r  <= H_IDLE;
      tm_r   <= 32'h0;
      tg_r   <= 1'b0;
      sup_r  <= 1'b0;
      down_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      ret_r  <= ret_nxt;
      tm_r   <= tm_nxt;
      tg_r   <= tg_nxt;
      sup_r  <= sup_nxt;
      down_r <= down_nxt;
    end
  end

  logic busy_r;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) busy_r <= 1'b0;
    else busy_r <= (st_r != H_IDLE) && (st_r != H_OFF);
  end
  assign link.toggle    = tg_r;
  assign link.supply_on = sup_r;
  assign busy_o         = busy_r;
endmodule

// file: sim/rpm_link_asserts.sv
// link-level checks between host and receiver sequencers
`timescale 1ns/1ps
module rpm_link_asserts
  import rpm_pkg::*;
#(
  parameter int unsigned MS_CYC = CYC_PER_MS  // clocks per ms tick
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic toggle,
  input wire logic supply_on,
  input wire logic wake_ind,
  input wire logic ant_stat
);
  // supply and gap counters saturate so long idle spells cannot wrap them
  localparam int unsigned SAT = 2 * BOOT_WAIT_MS * MS_CYC;
  int unsigned hi_cnt_r, hi_cnt_nxt;    // cycles toggle has been high
  int unsigned sup_cnt_r, sup_cnt_nxt;  // cycles supply has been on
  int unsigned gap_cnt_r, gap_cnt_nxt;  // cycles since toggle fell
  logic        seen_r, seen_nxt;        // wake seen since supply came up
  // next values of the helper counters
  always_comb begin
    hi_cnt_nxt  = toggle ? hi_cnt_r + 1 : 0;
    sup_cnt_nxt = !supply_on ? 0 : (sup_cnt_r < SAT ? sup_cnt_r + 1 : sup_cnt_r);
    gap_cnt_nxt = toggle ? 0 : (gap_cnt_r < SAT ? gap_cnt_r + 1 : gap_cnt_r);
    seen_nxt    = supply_on && (seen_r || wake_ind);
  end
  // registers only
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      hi_cnt_r  <= 0;
      sup_cnt_r <= 0;
      gap_cnt_r <= 0;
      seen_r    <= 1'b0;
    end else begin
      hi_cnt_r  <= hi_cnt_nxt;
      sup_cnt_r <= sup_cnt_nxt;
      gap_cnt_r <= gap_cnt_nxt;
      seen_r    <= seen_nxt;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // a pulse long enough to be taken has just ended
  sequence long_fall;
    $fell(toggle) && hi_cnt_r >= PULSE_MIN_MS * MS_CYC;
  endsequence
  chk_toggle_needs_sup: assert property (toggle |-> supply_on) else $error("toggle without supply");
  chk_pulse_width: assert property ($fell(toggle) |-> hi_cnt_r >= (PULSE_MS - 1) * MS_CYC
    && hi_cnt_r <= (PULSE_MS + 2) * MS_CYC) else $error("toggle pulse width off");
  chk_boot_wait: assert property ($rose(toggle) |-> seen_r
    || sup_cnt_r >= (BOOT_WAIT_MS - 2) * MS_CYC) else $error("pulse too soon after power-up");
  chk_stop_answer: assert property ((wake_ind and long_fall) |-> ##[1:8] !wake_ind)
    else $error("pulse in full power did not stop");
  chk_wake_answer: assert property (((supply_on && !wake_ind) and long_fall) |-> ##[1:8] wake_ind)
    else $error("valid pulse did not wake");
  chk_supply_hold: assert property ($fell(supply_on) |-> gap_cnt_r >= (SHUTDOWN_MS - 2) * MS_CYC)
    else $error("supply dropped too early");
  chk_no_abrupt_drop: assert property ($fell(supply_on) |-> !wake_ind)
    else $error("supply dropped while running");
  chk_toggle_gap: assert property ($fell(toggle) |=> !toggle [*8]) else $error("pulses too close");
endmodule

// file: sim/receiver_power_mode_sequencing_tb.sv
// self-checking bench: host and receiver ends joined over the link
`timescale 1ns/1ps
module receiver_power_mode_sequencing_tb;
  import rpm_pkg::*;
  localparam int unsigned MS = 10;  // shortened ms tick keeps the run short
  logic       clk_sys_i, nrst_i, msg_seen, hib_sel, ant_stat;
  logic [5:0] req;       // up, pulse, down, stop msg, ptf, aware
  logic [7:0] flush_sr;  // delays flush completion so stopping is visible
  logic       busy, flush_req, ant_pwr, ant_ok, rtc_run, sram_ret, refresh;
  logic [2:0] mode;
  logic       wake_d, refresh_seen;
  logic       exp_q[$];  // expected wake levels, oldest first
  int         bad_count, tests_run;
  rpm_link_if link();
  assign link.ant_stat = ant_stat;
  rpm_host #(.MS_CYC(MS)) u_rpm_host (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .link(link),
    .pwr_up_i(req[0]), .pulse_req_i(req[1]), .pwr_down_i(req[2]), .msg_seen_i(msg_seen),
    .uart_mode_i(1'b1), .busy_o(busy));
  rpm_device #(.PTF_PERIOD_CYC(300), .MS_CYC(MS)) u_rpm_device (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .link(link), .shutdown_cmd_i(req[3]), .ptf_cmd_i(req[4]), .aware_cmd_i(req[5]), .hib_sel_i(hib_sel),
    .flush_done_i(flush_sr[7]), .flush_req_o(flush_req), .ant_pwr_o(ant_pwr), .ant_ok_o(ant_ok),
    .rtc_run_o(rtc_run), .sram_ret_o(sram_ret), .refresh_o(refresh), .mode_o(mode));
  rpm_link_asserts #(.MS_CYC(MS)) u_rpm_link_asserts (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .toggle(link.toggle), .supply_on(link.supply_on), .wake_ind(link.wake_ind), .ant_stat(link.ant_stat));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // flush store answers eight cycles after it is asked
  always @(posedge clk_sys_i) flush_sr <= nrst_i ? {flush_sr[6:0], flush_req} : 8'h00;
  // monitor: every wake edge must match the oldest note
  always @(posedge clk_sys_i) begin
    if (refresh === 1'b1) refresh_seen <= 1'b1;
    if (nrst_i === 1'b1 && link.wake_ind !== wake_d) begin
      tests_run++;
      if (exp_q.size() == 0) fail("wake moved with nothing expected");
      else if (exp_q.pop_front() !== link.wake_ind) fail("wake level differs");
    end
    wake_d <= link.wake_ind;
  end
  task automatic fail(input string msg);
    $display("unexpected at %0t: %s", $time, msg);
    bad_count++;
  endtask
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) fail(msg);
  endtask
  task automatic give_verdict();
    chk(exp_q.size() == 0, "expected wake change never came");
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // bounded wait for a mode; running out ends the run
  task automatic wait_mode(input rpm_mode_t m, input int lim);
    int n;
    n = 0;
    while (mode !== m && n < lim) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk(mode === m, "mode not reached in time");
    if (mode !== m) give_verdict();
  endtask
  // b < 0: no request, the host or receiver acts by itself
  task automatic step(input int b, input logic w, input rpm_mode_t m, input int lim);
    int n;
    n = 0;
    while (b >= 0 && busy !== 1'b0 && n < 40000) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    if (busy !== 1'b0 && b >= 0) begin
      fail("host stayed busy");
      give_verdict();
    end
    repeat ($urandom % 8 + 1) @(posedge clk_sys_i);
    if (b >= 0) req[b] <= 1'b1;
    exp_q.push_back(w);
    @(posedge clk_sys_i);
    req <= '0;
    wait_mode(m, lim);
    $display("test done: mode %0d at %0t", m, $time);
  endtask
  initial begin
    {nrst_i, msg_seen, hib_sel, ant_stat, wake_d, refresh_seen, req, flush_sr} = '0;
    bad_count = 0;
    tests_run = 0;
    void'($urandom(62578));
    repeat (10) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    chk(mode === 3'h0 && link.wake_ind === 1'b0, "not idle after reset");
    step(0, 1'b1, RPM_FULL, 30000);
    step(-1, 1'b0, RPM_OFF, 30000);
    @(posedge clk_sys_i);
    msg_seen <= 1'b1;
    step(1, 1'b1, RPM_FULL, 3000);
    repeat (4) begin
      @(posedge clk_sys_i);
      ant_stat <= 1'($urandom % 2);
      repeat (6) @(posedge clk_sys_i);
      #1;
      chk(ant_pwr === 1'b1 && ant_ok === ant_stat, "antenna status wrong");
    end
    step(3, 1'b0, RPM_STOPPING, 50);
    chk(flush_req === 1'b1, "no flush while stopping");
    wait_mode(RPM_OFF, 6000);
    step(1, 1'b1, RPM_FULL, 3000);
    @(posedge clk_sys_i);
    hib_sel <= 1'b1;
    step(1, 1'b0, RPM_HIB, 3000);
    chk(sram_ret === 1'b1 && rtc_run === 1'b1, "hibernate lost retention");
    chk(ant_pwr === 1'b0, "antenna powered in hibernate");
    @(posedge clk_sys_i);
    hib_sel <= 1'b0;
    step(1, 1'b1, RPM_FULL, 3000);
    step(5, 1'b0, RPM_AWARE, 50);
    step(1, 1'b1, RPM_FULL, 3000);
    step(2, 1'b0, RPM_OFF, 6000);
    step(0, 1'b1, RPM_FULL, 30000);
    step(4, 1'b0, RPM_PTF_SLEEP, 50);
    step(-1, 1'b1, RPM_PTF_FIX, 3200);
    chk(refresh_seen === 1'b1, "no refresh on wake_indicator_out");
    // fix window ends, then a host pulse forces a fix before the period runs out
    step(-1, 1'b0, RPM_PTF_SLEEP, 11000);
    step(1, 1'b1, RPM_PTF_FIX, 2800);
    give_verdict();
  end
endmodule
